// ---- edbl_pkg.sv ----
`default_nettype none
package edbl_pkg;
   // Frame field values
   localparam logic [15:0] ETH_IP = 16'h0800;
   localparam logic [15:0] ETH_ARP = 16'h0806;
   localparam logic [7:0] IP_VIHL = 8'h45;
   localparam logic [7:0] IP_UDP = 8'h11;
   localparam logic [15:0] ARP_HTYPE = 16'h0001;
   localparam logic [7:0] ARP_HLEN = 8'h06;
   localparam logic [7:0] ARP_PLEN = 8'h04;
   localparam logic [15:0] ARP_REQ = 16'h0001;
   localparam logic [15:0] ARP_REP = 16'h0002;
   localparam logic [15:0] IP_FIXED_LEN = 16'h0026;
   localparam logic [15:0] IP_HDR_LEN = 16'h0014;

   // Byte index at which a received field is complete
   typedef logic [10:0] edbl_cnt_t;
   localparam edbl_cnt_t B_DST_HI = 11'h003;
   localparam edbl_cnt_t B_DST_LO = 11'h005;
   localparam edbl_cnt_t B_SRC_HI = 11'h009;
   localparam edbl_cnt_t B_SRC_LO = 11'h00b;
   localparam edbl_cnt_t B_TYPE = 11'h00d;
   localparam edbl_cnt_t B_VIHL = 11'h00e;
   localparam edbl_cnt_t B_TOS = 11'h00f;
   localparam edbl_cnt_t B_IDENT = 11'h013;
   localparam edbl_cnt_t B_FRAG = 11'h015;
   localparam edbl_cnt_t B_TTL = 11'h016;
   localparam edbl_cnt_t B_PROTO = 11'h017;
   localparam edbl_cnt_t B_SHA_HI = 11'h019;
   localparam edbl_cnt_t B_SHA_LO = 11'h01b;
   localparam edbl_cnt_t B_IPSRC = 11'h01d;
   localparam edbl_cnt_t B_SPA = 11'h01f;
   localparam edbl_cnt_t B_IPDST = 11'h021;
   localparam edbl_cnt_t B_PORT = 11'h023;
   localparam edbl_cnt_t B_TPA = 11'h029;
   localparam edbl_cnt_t B_CTRL = 11'h02f;
   localparam edbl_cnt_t B_ADDR = 11'h033;
   localparam edbl_cnt_t HDR_LEN = 11'h034;
   localparam edbl_cnt_t HDR_LAST = 11'h033;
   localparam edbl_cnt_t MIN_FRAME = 11'h03c;
   localparam edbl_cnt_t CNT_MAX = 11'h7ff;

   // Packet buffer: 4 slots of 512 bytes, 456 payload bytes each
   localparam logic [2:0] SLOTS = 3'h4;
   localparam logic [8:0] SLOT_WORDS = 9'h072;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;

   // Default addresses; MAC value is arbitrary
   localparam logic [31:0] IP_DEFAULT0 = 32'hc0a80010;
   localparam logic [31:0] IP_DEFAULT1 = 32'hc0a80020;
   localparam logic [47:0] MAC_DEFAULT0 = 48'h020000000010;
   localparam logic [47:0] MAC_DEFAULT1 = 48'h020000000020;

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_BUS = 4'h2,
      S_WAIT = 4'h4,
      S_TX = 4'h8
   } edbl_fsm_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic bad;
      logic [7:0] data;
   } edbl_rx_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } edbl_tx_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } edbl_bus_t;

   typedef struct packed {
      logic ipWrite;
      logic [31:0] ipData;
      logic macWrite;
      logic [47:0] macData;
      logic disWrite;
      logic disData;
   } edbl_cfg_t;

   typedef struct packed {
      logic arp;
      logic [47:0] srcMac;
      logic [31:0] srcIp;
      logic [7:0] tos;
      logic [15:0] ident;
      logic [15:0] frag;
      logic [7:0] ttl;
      logic [15:0] port;
      logic [13:0] seq;
      logic rw;
      logic [9:0] len;
      logic [6:0] unused;
      logic [31:0] addr;
   } edbl_slot_t;
endpackage
`default_nettype wire

// ---- edbl_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Claimed frames are withheld from receive DMA
// - Claim by own MAC; ARP by IP
// - Valid commands run on shared bus master
// - Reply sent automatically, priority over DMA
// - Accept only matching MAC (ARP also broadcast), IP/ARP type
// - IP checksum/ident unchecked; reply changes length, checksum
// - Port ignored; reply echoes port, zero checksum
// - Alignment halfword accepted with any value
// - Flag zero reads, one writes
// - Length in bytes; writes carry data
// - Reply length zero for writes, bytes for reads
// - Sequence mismatch: skip, NAK, current counter
// - Sequence match: operate, increment, ACK
// - Unused field copied into reply
// - Address low nibbles loaded from straps
// - Default IP per controller, software writable
// - Four slot buffer; drop when full
// - Standard ARP replies for own IP
// - Disable bit resets to inverse enable input
module edbl_core import edbl_pkg::*; #(
   parameter int unsigned CTRL_INDEX = 0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire edbl_rx_t rxIn,
   output logic rxClaim,
   input wire logic [3:0] addrStrap,
   input wire logic debugSupportEnableInput,
   input wire edbl_cfg_t cfgIn,
   output logic debugLinkDisable,
   output var edbl_bus_t busOut,
   input wire logic busDone,
   input wire logic [31:0] busRdata,
   output var edbl_tx_t txOut,
   input wire logic txReady,
   output logic txRequest,
   input wire logic dmaTxActive
);
   localparam logic [31:0] IP_DEFAULT = (CTRL_INDEX == 0) ? IP_DEFAULT0 : IP_DEFAULT1;
   localparam logic [47:0] MAC_DEFAULT = (CTRL_INDEX == 0) ? MAC_DEFAULT0 : MAC_DEFAULT1;

   typedef struct packed {
      logic strapDone;
      logic [31:0] ip;
      logic [47:0] mac;
      logic linkDisable;
      logic [31:0] sh;
      edbl_cnt_t rxCnt;
      logic dstMe;
      logic dstBc;
      logic isIp;
      logic isArp;
      logic drop;
      logic claim;
      edbl_slot_t cap;
      edbl_slot_t [3:0] slots;
      logic [1:0] wrPtr;
      logic [1:0] rdPtr;
      logic [2:0] used;
      edbl_fsm_t fsm;
      logic [13:0] seqCnt;
      logic [6:0] wordIdx;
      logic [7:0] wordCnt;
      logic ack;
      logic [9:0] rlen;
      edbl_cnt_t txCnt;
      logic inFcs;
      logic [31:0] crc;
      edbl_tx_t tx;
      logic txReq;
      edbl_bus_t bus;
   } edbl_state_t;

   edbl_state_t st, nx;
   logic [31:0] mem [4][128];
   logic [31:0] sh, txWord, busWord, crcNext, fcs;
   logic [10:0] rxOff, byteIdx, txOff, frameEnd;
   logic rxWe, busWe, commit, freeSlot;
   logic [7:0] nextByte;
   edbl_slot_t cur;

   // Reflected CRC-32, one byte
   function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Header checksum over the reply header; swapped addresses leave the sum unchanged
   function automatic logic [15:0] ipSum(input edbl_slot_t s, input logic [31:0] ip, input logic [15:0] len);
      logic [31:0] a;
      a = {16'h0, IP_VIHL, s.tos} + {16'h0, len} + {16'h0, s.ident} + {16'h0, s.frag}
         + {16'h0, s.ttl, IP_UDP} + {16'h0, ip[31:16]} + {16'h0, ip[15:0]}
         + {16'h0, s.srcIp[31:16]} + {16'h0, s.srcIp[15:0]};
      a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
      a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
      return ~a[15:0];
   endfunction

   // Byte idx of the reply frame, destination address first, FCS excluded
   function automatic logic [7:0] frameByte(input edbl_slot_t s, input logic [31:0] ip, input logic [47:0] mac,
                                            input logic ack, input logic [9:0] rlen, input logic [13:0] seq,
                                            input logic [10:0] idx, input logic [31:0] word);
      logic [415:0] hdr;
      logic [15:0] ipLen;
      logic [10:0] dOff;
      logic [31:0] w;
      ipLen = IP_FIXED_LEN + {6'h0, rlen};
      dOff = idx - HDR_LEN;
      if (s.arp) begin
         hdr = {s.srcMac, mac, ETH_ARP, ARP_HTYPE, ETH_IP, ARP_HLEN, ARP_PLEN, ARP_REP,
                mac, ip, s.srcMac, s.srcIp, 80'h0};
      end else begin
         hdr = {s.srcMac, mac, ETH_IP, IP_VIHL, s.tos, ipLen, s.ident, s.frag, s.ttl, IP_UDP,
                ipSum(s, ip, ipLen), ip, s.srcIp,
                s.port, s.port, ipLen - IP_HDR_LEN, 16'h0,
                16'h0, seq, ack, rlen, s.unused, s.addr};
      end
      if (idx < HDR_LEN) begin
         hdr = hdr >> {HDR_LAST - idx, 3'h0};
         return hdr[7:0];
      end else if (dOff < {1'b0, rlen}) begin
         w = word >> {~dOff[1:0], 3'h0};
         return w[7:0];
      end
      return 8'h00;
   endfunction

   // Buffer reads for transmit and for bus write data
   always_comb begin
      cur = st.slots[st.rdPtr];
      byteIdx = (st.fsm == S_WAIT) ? 11'h000 : 11'(st.txCnt + 11'h001);
      txOff = byteIdx - HDR_LEN;
      txWord = mem[st.rdPtr][txOff[8:2]];
      busWord = mem[st.rdPtr][(st.fsm == S_IDLE) ? 7'h00 : 7'(st.wordIdx + 7'h01)];
      nextByte = frameByte(cur, st.ip, st.mac, st.ack, st.rlen, st.seqCnt, byteIdx, txWord);
      frameEnd = 11'(((HDR_LEN + {1'b0, st.rlen}) < MIN_FRAME ? MIN_FRAME : HDR_LEN + {1'b0, st.rlen}) - 11'h001);
      crcNext = crcByte(st.crc, st.tx.data);
      fcs = ~st.crc;
      sh = {st.sh[23:0], rxIn.data};
      rxOff = st.rxCnt - HDR_LEN;
   end

   // Next state
   always_comb begin
      nx = st;
      rxWe = 1'b0;
      busWe = 1'b0;
      commit = 1'b0;
      freeSlot = 1'b0;
      // Straps are caught on the first edge after reset release
      if (!st.strapDone) begin
         nx.strapDone = 1'b1;
         nx.ip = {IP_DEFAULT[31:4], addrStrap};
         nx.mac = {MAC_DEFAULT[47:4], addrStrap};
         nx.linkDisable = ~debugSupportEnableInput;
      end else begin
         if (cfgIn.ipWrite) nx.ip = cfgIn.ipData;
         if (cfgIn.macWrite) nx.mac = cfgIn.macData;
         if (cfgIn.disWrite) nx.linkDisable = cfgIn.disData;
      end

      // Receive parser; checksum and identification are never checked, alignment halfword skipped
      if (rxIn.valid) begin
         nx.sh = sh;
         nx.rxCnt = (st.rxCnt == CNT_MAX) ? st.rxCnt : 11'(st.rxCnt + 11'h001);
         case (st.rxCnt)
            B_DST_HI: begin
               nx.dstMe = (sh == st.mac[47:16]);
               nx.dstBc = &sh;
            end
            B_DST_LO: begin
               nx.dstMe = st.dstMe && (sh[15:0] == st.mac[15:0]);
               nx.dstBc = st.dstBc && (&sh[15:0]);
            end
            B_SRC_HI: nx.cap.srcMac[47:16] = sh;
            B_SRC_LO: nx.cap.srcMac[15:0] = sh[15:0];
            B_TYPE: begin
               nx.isIp = !st.linkDisable && st.dstMe && (sh[15:0] == ETH_IP);
               nx.isArp = !st.linkDisable && (st.dstMe || st.dstBc) && (sh[15:0] == ETH_ARP);
               nx.claim = nx.isIp;
            end
            B_VIHL: if (st.isIp && sh[7:0] != IP_VIHL) nx.drop = 1'b1;
            B_TOS: nx.cap.tos = sh[7:0];
            B_IDENT: nx.cap.ident = sh[15:0];
            B_FRAG: begin
               nx.cap.frag = sh[15:0];
               if (st.isArp && sh[15:0] != ARP_REQ) nx.drop = 1'b1;
            end
            B_TTL: nx.cap.ttl = sh[7:0];
            B_PROTO: if (st.isIp && sh[7:0] != IP_UDP) nx.drop = 1'b1;
            B_SHA_HI: if (st.isArp) nx.cap.srcMac[47:16] = sh;
            B_SHA_LO: if (st.isArp) nx.cap.srcMac[15:0] = sh[15:0];
            B_IPSRC: if (st.isIp) nx.cap.srcIp = sh;
            B_SPA: if (st.isArp) nx.cap.srcIp = sh;
            B_IPDST: if (st.isIp && sh != st.ip) nx.drop = 1'b1;
            B_PORT: nx.cap.port = sh[15:0];
            B_TPA: if (st.isArp) begin
               nx.claim = (sh == st.ip);
               nx.isArp = (sh == st.ip);
            end
            B_CTRL: begin
               nx.cap.seq = sh[31:18];
               nx.cap.rw = sh[17];
               nx.cap.len = sh[16:7];
               nx.cap.unused = sh[6:0];
            end
            B_ADDR: nx.cap.addr = sh;
            default: ; // Alignment halfword, checksum and ident pass unchecked
         endcase
         // Write data words; none while full, as the write pointer then names a busy slot; past the slot is lost
         rxWe = st.isIp && (st.rxCnt >= HDR_LEN) && (st.rxCnt[1:0] == 2'h3) && (st.used != SLOTS)
                && ({1'b0, rxOff[10:2]} < {1'b0, SLOT_WORDS});
         if (rxIn.last) begin
            nx.rxCnt = 11'h000;
            nx.dstMe = 1'b0;
            nx.dstBc = 1'b0;
            nx.isIp = 1'b0;
            nx.isArp = 1'b0;
            nx.drop = 1'b0;
            nx.claim = 1'b0;
            // Full buffer drops the frame, though it stays claimed
            commit = ((st.isIp && st.rxCnt >= B_ADDR) || st.isArp) && !st.drop && !rxIn.bad
                     && (st.used != SLOTS);
            if (commit) begin
               nx.slots[st.wrPtr] = st.cap;
               nx.slots[st.wrPtr].arp = st.isArp;
               nx.wrPtr = 2'(st.wrPtr + 2'h1);
            end
         end
      end

      // Command processing and reply, one slot at a time in arrival order
      unique case (st.fsm)
         S_IDLE: if (st.used != 3'h0) begin
            nx.fsm = S_WAIT;
            nx.ack = 1'b0;
            nx.rlen = 10'h000;
            nx.wordIdx = 7'h00;
            nx.wordCnt = 8'((cur.len + 10'h003) >> 2) > 8'(SLOT_WORDS) ? 8'(SLOT_WORDS)
                         : 8'((cur.len + 10'h003) >> 2);
            if (cur.arp) begin
               nx.fsm = S_WAIT;
            end else if (cur.seq != st.seqCnt) begin
               nx.ack = 1'b1;
            end else begin
               nx.rlen = cur.rw ? 10'h000 : cur.len;
               if (cur.len == 10'h000) begin
                  nx.seqCnt = 14'(st.seqCnt + 14'h0001);
               end else begin
                  nx.fsm = S_BUS;
                  nx.bus.req = 1'b1;
                  nx.bus.write = cur.rw;
                  nx.bus.addr = cur.addr;
                  nx.bus.wdata = busWord;
               end
            end
         end
         S_BUS: if (busDone) begin
            busWe = !st.bus.write;
            if ({1'b0, st.wordIdx} == 8'(st.wordCnt - 8'h01)) begin
               nx.bus.req = 1'b0;
               nx.seqCnt = 14'(st.seqCnt + 14'h0001);
               nx.fsm = S_WAIT;
            end else begin
               nx.wordIdx = 7'(st.wordIdx + 7'h01);
               nx.bus.addr = 32'(st.bus.addr + 32'h4);
               nx.bus.wdata = busWord;
            end
         end
         S_WAIT: begin
            // Hold off DMA first, then start once its frame is over
            nx.txReq = 1'b1;
            if (st.txReq && !dmaTxActive) begin
               nx.fsm = S_TX;
               nx.txCnt = 11'h000;
               nx.inFcs = 1'b0;
               nx.crc = CRC_INIT;
               nx.tx.valid = 1'b1;
               nx.tx.last = 1'b0;
               nx.tx.data = nextByte;
            end
         end
         S_TX: if (txReady) begin
            if (!st.inFcs) begin
               nx.crc = crcNext;
               if (st.txCnt == frameEnd) begin
                  nx.inFcs = 1'b1;
                  nx.txCnt = 11'h000;
                  nx.tx.data = ~crcNext[7:0];
               end else begin
                  nx.txCnt = 11'(st.txCnt + 11'h001);
                  nx.tx.data = nextByte;
               end
            end else if (st.txCnt[1:0] == FCS_LAST) begin
               nx.tx = '0;
               nx.txReq = 1'b0;
               nx.inFcs = 1'b0;
               nx.fsm = S_IDLE;
               freeSlot = 1'b1;
               nx.rdPtr = 2'(st.rdPtr + 2'h1);
            end else begin
               nx.txCnt = 11'(st.txCnt + 11'h001);
               nx.tx.data = 8'(fcs >> {st.txCnt[1:0] + 2'h1, 3'h0});
               nx.tx.last = (st.txCnt[1:0] == 2'h2);
            end
         end
      endcase
      // Slot occupancy; a commit and a release in one cycle cancel
      nx.used = 3'(st.used + {2'h0, commit} - {2'h0, freeSlot});
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.fsm <= S_IDLE;
      end else begin
         st <= nx;
      end
   end

   // Packet data store, receive writes the free slot, reads fill the active one
   always_ff @(posedge core_clk) begin
      if (rxWe) mem[st.wrPtr][rxOff[8:2]] <= sh;
      if (busWe) mem[st.rdPtr][st.wordIdx] <= busRdata;
   end

   assign rxClaim = st.claim;
   assign debugLinkDisable = st.linkDisable;
   assign busOut = st.bus;
   assign txOut = st.tx;
   assign txRequest = st.txReq;
endmodule
`default_nettype wire

// ---- edbl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// Claim, bus and reply handshakes seen at the core's ports
module edbl_props import edbl_pkg::*; (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire edbl_rx_t rxIn,
   input wire logic rxClaim,
   input wire logic debugLinkDisable,
   input wire edbl_bus_t busOut,
   input wire logic busDone,
   input wire edbl_tx_t txOut,
   input wire logic txReady,
   input wire logic txRequest,
   input wire logic dmaTxActive
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Receive DMA samples the claim with the last byte, so it must drop right after
   property p_claim_end; rxIn.valid && rxIn.last |=> !rxClaim; endproperty
   a_claim_end: assert property (p_claim_end) else $error("claim held past frame end");
   property p_claim_rise; $rose(rxClaim) |-> $past(rxIn.valid); endproperty
   a_claim_rise: assert property (p_claim_rise) else $error("claim rose without a byte");
   property p_off; debugLinkDisable && rxIn.valid |=> !$rose(rxClaim); endproperty
   a_off: assert property (p_off) else $error("frame claimed while link off");
   property p_bus_hold; busOut.req && !busDone |=> busOut.req && $stable(busOut.addr) &&
      $stable(busOut.write) && $stable(busOut.wdata); endproperty
   a_bus_hold: assert property (p_bus_hold) else $error("bus request changed before done");
   property p_bus_next; busOut.req && busDone |=> !busOut.req || busOut.addr == $past(busOut.addr) + 32'h4;
   endproperty
   a_bus_next: assert property (p_bus_next) else $error("next word address not ascending");
   property p_tx_start; $rose(txOut.valid) |-> $past(txRequest) && !$past(dmaTxActive); endproperty
   a_tx_start: assert property (p_tx_start) else $error("reply started over transmit DMA");
   property p_tx_hold; txOut.valid && !txReady |=> txOut.valid && $stable(txOut.data) && $stable(txOut.last);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped while stalled");
   property p_tx_end; txOut.valid && txOut.last && txReady |=> !txOut.valid && !txRequest; endproperty
   a_tx_end: assert property (p_tx_end) else $error("transmitter kept after last byte");
endmodule
bind edbl_core edbl_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .rxIn(rxIn), .rxClaim(rxClaim),
   .debugLinkDisable(debugLinkDisable), .busOut(busOut), .busDone(busDone), .txOut(txOut),
   .txReady(txReady), .txRequest(txRequest), .dmaTxActive(dmaTxActive));
`default_nettype wire

// ---- edbl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Remote debug host: sends frames byte by byte and collects replies
module edbl_host_model import edbl_pkg::*; (
   input wire logic core_clk,
   input wire edbl_tx_t txOut,
   output var edbl_rx_t rxIn,
   output logic txReady
);
   logic [7:0] got[$];
   logic [1:0] stallCnt;
   initial begin
      rxIn = '0;
      txReady = 1'b0;
      stallCnt = 2'h0;
   end
   // Refuses one cycle in four so every reply meets back-pressure
   always @(posedge core_clk) begin
      stallCnt <= stallCnt + 2'h1;
      txReady <= (stallCnt != 2'h3);
      if (txOut.valid && txReady) got.push_back(txOut.data);
   end
   task automatic send(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++) begin
         @(posedge core_clk);
         rxIn <= {1'b1, i == f.size() - 1, 1'b0, f[i]};
      end
      @(posedge core_clk);
      // Idle data shows a changed value so a stale byte cannot pass
      rxIn <= {3'h0, ~f[f.size() - 1]};
   endtask
endmodule
`default_nettype wire

// ---- edbl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench import edbl_pkg::*;;
   localparam logic [3:0] STRAP = 4'h5;
   localparam logic [47:0] ownMac = {MAC_DEFAULT0[47:4], STRAP};
   localparam logic [31:0] ownIp = {IP_DEFAULT0[31:4], STRAP};
   localparam logic [47:0] hostMac = 48'h0a0b0c0d0e0f;
   localparam logic [31:0] hostIp = 32'hc0a80001;
   localparam logic [15:0] PORT = 16'h1234;
   localparam logic [31:0] ADDR = 32'h40001000;
   localparam logic [6:0] UNUSED = 7'h5b;
   logic core_clk, sys_rst, rxClaim, debugLinkDisable, busDone, txReady, txRequest, dmaTxActive, lastClaim;
   logic supportEnable;
   edbl_rx_t rxIn;
   edbl_tx_t txOut;
   edbl_cfg_t cfgIn;
   edbl_bus_t busOut;
   logic [31:0] busRdata;
   logic [64:0] bq[$];
   int fail_count, n_checks;
   edbl_core #(.CTRL_INDEX(0)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .rxIn(rxIn), .rxClaim(rxClaim),
      .addrStrap(STRAP), .debugSupportEnableInput(supportEnable), .cfgIn(cfgIn),
      .debugLinkDisable(debugLinkDisable), .busOut(busOut), .busDone(busDone), .busRdata(busRdata),
      .txOut(txOut), .txReady(txReady),
      .txRequest(txRequest), .dmaTxActive(dmaTxActive));
   edbl_host_model host (.core_clk(core_clk), .txOut(txOut), .rxIn(rxIn), .txReady(txReady));
   always #10 core_clk = ~core_clk;
   // Bus slave answers every word one cycle late; read data is an address pattern
   always @(posedge core_clk) begin
      busDone <= busOut.req && !busDone;
      busRdata <= (busOut.req && !busDone) ? busOut.addr ^ 32'h5a5a0000 : ~busRdata;
      if (busOut.req && busDone) bq.push_back({busOut.write, busOut.addr, busOut.wdata});
      if (rxIn.valid && rxIn.last) lastClaim <= rxClaim;
   end
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [63:0] fld(input int i, input int n);
      logic [63:0] v;
      v = '0;
      for (int k = 0; k < n; k++) v = {v[55:0], host.got[i + k]};
      return v;
   endfunction
   // Running the CRC over frame and FCS together must leave the fixed residue
   function automatic logic [31:0] crc_all();
      logic [31:0] c;
      c = CRC_INIT;
      foreach (host.got[i]) begin
         c = c ^ {24'h0, host.got[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // A sound reply header sums, in ones' complement, to all ones
   function automatic logic [15:0] ip_sum();
      logic [31:0] s;
      s = 32'h0;
      for (int i = 14; i < 34; i += 2) s += 32'(fld(i, 2));
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      return s[15:0];
   endfunction
   task automatic send_frame(input logic [479:0] v);
      logic [7:0] f[$];
      for (int i = 0; i < 60; i++) f.push_back(v[479 - 8 * i -: 8]);
      repeat (4) f.push_back(8'h00); // Errors come on rxIn.bad, the core trusts the MAC
      host.got.delete();
      bq.delete();
      host.send(f);
      @(negedge core_clk);
   endtask
   // Ident, header checksum and alignment carry junk the core must ignore
   task automatic send_cmd(input logic [15:0] ety, input logic [13:0] seq, input logic rw,
      input logic [9:0] len, input logic [63:0] data);
      send_frame({ownMac, hostMac, ety, IP_VIHL, 8'h00, 16'h0026 + {6'h0, len}, 16'hbeef, 16'h0000, 8'h40,
         IP_UDP, 16'hffff, hostIp, ownIp, PORT, 16'h0999, 16'h0012 + {6'h0, len}, 16'h0000, 16'hffff,
         seq, rw, len, UNUSED, ADDR, data});
   endtask
   task automatic wait_reply();
      int k;
      k = 0;
      while (host.got.size() < 64 || txOut.valid !== 1'b0) begin
         @(negedge core_clk);
         k++;
         if (k > 4000) begin
            fail_count++;
            $display("BAD t=%0t reply missing got=%h exp=%h", $time, host.got.size(), 64);
            summarize();
         end
      end
   endtask
   task automatic chk_reply(input logic [13:0] seq, input logic ack, input logic [9:0] len, input logic [31:0] rd);
      wait_reply();
      chk(host.got.size(), 64);
      chk(fld(0, 8), {hostMac, ownMac[47:32]});
      chk(fld(16, 4), {16'h0026 + {6'h0, len}, 16'hbeef});
      chk(ip_sum(), 16'hffff);
      chk(fld(26, 8), {ownIp, hostIp});
      chk(fld(34, 4), {PORT, PORT});
      chk(fld(40, 2), 16'h0000);
      chk(fld(44, 4), {seq, ack, len, UNUSED});
      if (len != 10'h0) chk(fld(52, 4), rd);
      chk(crc_all(), 32'hdebb20e3);
   endtask
   task automatic t_arp();
      @(posedge core_clk);
      dmaTxActive <= 1'b1;
      send_frame({48'hffffffffffff, hostMac, ETH_ARP, ARP_HTYPE, ETH_IP, ARP_HLEN, ARP_PLEN, ARP_REQ,
         hostMac, hostIp, 48'h0, ownIp, 144'h0});
      chk(lastClaim, 1'b1);
      repeat (40) @(posedge core_clk);
      chk(txRequest, 1'b1);
      chk(host.got.size(), 0);
      dmaTxActive <= 1'b0;
      wait_reply();
      chk(fld(0, 8), {hostMac, ownMac[47:32]});
      chk(fld(12, 2), ETH_ARP);
      chk(fld(20, 8), {ARP_REP, ownMac});
      chk(fld(28, 4), ownIp);
      chk(fld(32, 8), {hostMac, hostIp[31:16]});
      chk(crc_all(), 32'hdebb20e3);
      $display("arp test done");
   endtask
   task automatic t_cmds();
      send_cmd(ETH_IP, 14'h0, 1'b1, 10'h8, 64'h11223344aabbccdd);
      chk_reply(14'h1, 1'b0, 10'h0, 32'h0);
      chk(lastClaim, 1'b1);
      chk(bq.size(), 2);
      chk(bq[0], {1'b1, ADDR, 32'h11223344});
      chk(bq[1], {1'b1, ADDR + 32'h4, 32'haabbccdd});
      send_cmd(ETH_IP, 14'h1, 1'b0, 10'h4, 64'h0);
      chk_reply(14'h2, 1'b0, 10'h4, ADDR ^ 32'h5a5a0000);
      chk(bq[0][64:32], {1'b0, ADDR});
      send_cmd(ETH_IP, 14'h5, 1'b1, 10'h4, 64'h0);
      chk_reply(14'h2, 1'b1, 10'h0, 32'h0);
      chk(bq.size(), 0);
      $display("command test done");
   endtask
   // Five commands while replies are held off: the fifth meets four busy slots and is dropped
   task automatic t_full();
      @(posedge core_clk);
      dmaTxActive <= 1'b1;
      for (int i = 2; i < 7; i++) send_cmd(ETH_IP, 14'(i), 1'b1, 10'h0, 64'h0);
      chk(lastClaim, 1'b1);
      @(posedge core_clk);
      dmaTxActive <= 1'b0;
      repeat (1500) @(posedge core_clk);
      chk(host.got.size(), 256);
      chk(fld(236, 4), {14'h6, 1'b0, 10'h0, UNUSED});
      $display("full buffer test done");
   endtask
   // Reset, also mid-run: the disable bit comes back as the inverse of the enable input
   task automatic t_reset(input logic en);
      sys_rst <= 1'b1;
      supportEnable <= en;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(debugLinkDisable, !en);
      $display("reset test done");
      @(posedge core_clk);
   endtask
   task automatic t_drop();
      send_cmd(16'h86dd, 14'h2, 1'b1, 10'h4, 64'h0);
      chk(lastClaim, 1'b0);
      @(posedge core_clk);
      cfgIn.disWrite <= 1'b1;
      cfgIn.disData <= 1'b1;
      @(posedge core_clk);
      cfgIn.disWrite <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(debugLinkDisable, 1'b1);
      send_frame({48'hffffffffffff, hostMac, ETH_ARP, ARP_HTYPE, ETH_IP, ARP_HLEN, ARP_PLEN, ARP_REQ,
         hostMac, hostIp, 48'h0, ownIp, 144'h0});
      chk(lastClaim, 1'b0);
      repeat (300) @(posedge core_clk);
      chk(host.got.size(), 0);
      chk(bq.size(), 0);
      $display("drop test done");
   endtask
   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      cfgIn = '0;
      busDone = 1'b0;
      busRdata = 32'h0;
      dmaTxActive = 1'b0;
      lastClaim = 1'b0;
      fail_count = 0;
      n_checks = 0;
      t_reset(1'b1);
      t_arp();
      t_cmds();
      t_full();
      t_drop();
      t_reset(1'b0);
      summarize();
   end
endmodule
`default_nettype wire
